// ---- core/smc_pkg.sv ----
// Package holding register map, field layout and timing constants for the memory control block.
// Behaviour
// RQ1: Ratio field selects divide two to five.
// RQ2: Old ratio kept until start bit rises.
// RQ3: Software clears start bit before setting it.
// RQ4: Refresh every interval times 64 clocks; zero disables.
// RQ5: Stagger between bank refreshes: 0,1,2,4 clocks.
// RQ6: Software sets stagger zero for single bank.
// RQ7: Address setup adds one clock before select.
// RQ8: Test refresh bit requests a refresh.
// RQ9: Arbitration bit picks round robin or processor first.
// RQ10: High priority display always wins arbitration.
// RQ11: Wrap bit allows access into legacy window.
// RQ12: Mode bit rising issues mode register command.
// RQ13: Software clears mode bit before setting it.
// RQ14: Bus drive fields: zero tristates, seven strongest.
// RQ15: Clock drive: zero and seven both strongest.
// RQ16: Rise delay applies in every divide mode.
// RQ17: Fall delay applies only in half modes; the code applies it at ratios 2.5 and 3.5 only, not at 4.5.
// RQ18: Feedback clock mask stops that output.
// RQ19: Four module clock masks stop each clock.
// RQ20: Shift value waits for start bit rising.
// RQ21: Rising edges found by comparing previous sample.
package smc_pkg;
  localparam logic [15:0] ADDR_CTRL_ONE = 16'h8400;
  localparam logic [15:0] ADDR_CTRL_TWO = 16'h8404;
  localparam logic [31:0] RST_CTRL_ONE = 32'h248c_0040;
  localparam logic [31:0] RST_CTRL_TWO = 32'h0000_0801;
  localparam logic [31:0] WMASK_CTRL_ONE = 32'hff9f_fffd;
  localparam logic [31:0] WMASK_CTRL_TWO = 32'h0003_fffb;
  localparam int DATA_DRV_HI = 31;
  localparam int ADDR_DRV_HI = 28;
  localparam int CTRL_DRV_HI = 25;
  localparam int RATIO_HI = 20;
  localparam int START_BIT = 17;
  localparam int RINT_HI = 16;
  localparam int RINT_LO = 8;
  localparam int STAG_HI = 7;
  localparam int SETUP_BIT = 5;
  localparam int TREF_BIT = 4;
  localparam int ARB_BIT = 3;
  localparam int WRAP_BIT = 2;
  localparam int MODE_BIT = 0;
  localparam int RISE_HI = 17;
  localparam int FALL_HI = 15;
  localparam int CDRV_HI = 13;
  localparam int FBMASK_BIT = 10;
  localparam int MODMASK_HI = 9;
  localparam int SHIFT_HI = 5;
  localparam int REFRESH_UNIT = 64;
  localparam logic [2:0] RATIO_RSVD = 3'h0;
  localparam logic [2:0] RATIO_2P5 = 3'h2;
  localparam logic [2:0] RATIO_3P5 = 3'h4;
  localparam logic [2:0] RATIO_DEFAULT = 3'h3;
  localparam logic [2:0] DRV_TRI = 3'h0;
  localparam logic [2:0] DRV_MAX = 3'h7;
  typedef struct packed {
    logic [2:0] ratio;
    logic [2:0] shift;
  } smc_clkcfg_s;
  typedef enum logic [1:0] {
    SMC_GNT_NONE,
    SMC_GNT_DISP,
    SMC_GNT_CPU,
    SMC_GNT_GFX
  } smc_gnt_e;
endpackage

// ---- core/smc_ctrl.sv ----
// Configuration and control logic of the memory controller.
module smc_ctrl #(
  parameter int RINT_W = 9
) (
  input wire logic clock, // Core clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [15:0] reg_addr, // Register offset.
  input wire logic reg_wr, // Write strobe.
  input wire logic [31:0] reg_wdata, // Write data.
  output logic [31:0] reg_rdata, // Read data, registered.
  input wire logic req_disp_hi, // High priority display request.
  input wire logic req_cpu, // Processor request.
  input wire logic req_gfx, // Graphics and low priority display request.
  output smc_pkg::smc_gnt_e grant, // Arbitration grant.
  input wire logic [19:0] access_addr, // Incoming memory access address.
  output logic access_block, // Access refused: wrap into legacy window disabled.
  input wire logic cmd_start, // Memory command about to be issued.
  output logic cs_n, // Chip select, active low.
  output logic addr_valid, // Address driven toward memory.
  output logic refresh_req, // One-cycle refresh request.
  output logic [1:0] ref_bank, // Bank being refreshed.
  output logic mrs_cmd, // One-cycle mode register command.
  input wire logic [2:0] cas_latency_setting, // Latency from timing register.
  output logic [2:0] mrs_latency, // Latency carried by the command.
  output smc_pkg::smc_clkcfg_s clk_active, // Ratio and shift in use.
  output logic [3:0] clk_half_step, // Divide ratio in half core clocks.
  output logic [1:0] rise_delay, // Rising edge delay in use.
  output logic [1:0] fall_delay, // Falling edge delay in use.
  output logic [2:0] data_drv, // Data bus drive; zero tristates.
  output logic [2:0] addr_drv, // Address bus drive; zero tristates.
  output logic [2:0] ctrl_drv, // Control bus drive; zero tristates.
  output logic [2:0] clk_drv, // Clock drive, normalised to seven for strongest.
  output logic fb_clk_en, // Feedback clock running.
  output logic [3:0] mod_clk_en // Module clocks running.
);
  typedef struct packed {
    logic [31:0] one;
    logic [31:0] two;
    logic start_q;
    logic mode_q;
    logic tref_q;
    smc_pkg::smc_clkcfg_s clk;
    logic [RINT_W+5:0] rcnt;
    logic [2:0] stag_cnt;
    logic [1:0] bank;
    logic ref_busy;
    logic refresh;
    logic mrs;
    logic [2:0] lat;
    logic setup;
    logic cs;
    logic [31:0] rdata;
    logic rr_last_cpu;
    smc_pkg::smc_gnt_e gnt;
  } smc_state_s;

  smc_state_s st_r;
  smc_state_s st_nxt;

  // Converts a stagger code to the gap in clocks.
  function automatic logic [2:0] stag_gap(input logic [1:0] code);
    case (code)
      2'h0: stag_gap = 3'h0;
      2'h1: stag_gap = 3'h1;
      2'h2: stag_gap = 3'h2;
      default: stag_gap = 3'h4;
    endcase
  endfunction

  // Next-state logic for registers, edges, refresh, commands and arbitration.
  always_comb begin
    logic [RINT_W-1:0] rint;
    logic tick;
    rint = st_r.one[smc_pkg::RINT_HI:smc_pkg::RINT_LO];
    st_nxt = st_r;
    st_nxt.refresh = 1'b0;
    st_nxt.mrs = 1'b0;
    if (reg_wr && reg_addr == smc_pkg::ADDR_CTRL_ONE) begin
      st_nxt.one = reg_wdata & smc_pkg::WMASK_CTRL_ONE;
    end
    if (reg_wr && reg_addr == smc_pkg::ADDR_CTRL_TWO) begin
      st_nxt.two = reg_wdata & smc_pkg::WMASK_CTRL_TWO;
    end
    st_nxt.start_q = st_r.one[smc_pkg::START_BIT]; // [RQ21]
    st_nxt.mode_q = st_r.one[smc_pkg::MODE_BIT]; // [RQ21]
    st_nxt.tref_q = st_r.one[smc_pkg::TREF_BIT];
    // Ratio and shift are only adopted on a start rising edge.
    if (st_r.one[smc_pkg::START_BIT] && !st_r.start_q) begin // [RQ2] [RQ20]
      if (st_r.one[smc_pkg::RATIO_HI -: 3] != smc_pkg::RATIO_RSVD) begin // [RQ1]
        st_nxt.clk.ratio = st_r.one[smc_pkg::RATIO_HI -: 3];
      end
      st_nxt.clk.shift = st_r.two[smc_pkg::SHIFT_HI -: 3];
    end
    // Mode register command on rising edge of the request bit.
    if (st_r.one[smc_pkg::MODE_BIT] && !st_r.mode_q) begin // [RQ12]
      st_nxt.mrs = 1'b1;
      st_nxt.lat = cas_latency_setting;
    end
    // Interval counter; zero interval holds it idle.
    tick = 1'b0;
    if (rint == '0) begin // [RQ4]
      st_nxt.rcnt = '0;
    end else if (st_r.rcnt >= (RINT_W+6)'(rint * smc_pkg::REFRESH_UNIT - 1)) begin // [RQ4]
      st_nxt.rcnt = '0;
      tick = 1'b1;
    end else begin
      st_nxt.rcnt = st_r.rcnt + 1'b1;
    end
    if (st_r.one[smc_pkg::TREF_BIT] && !st_r.tref_q) begin // [RQ8]
      tick = 1'b1;
    end
    // Staggered bank refresh sequence across four banks.
    if (tick && !st_r.ref_busy) begin
      st_nxt.ref_busy = 1'b1;
      st_nxt.bank = 2'h0;
      st_nxt.stag_cnt = 3'h0;
    end else if (st_r.ref_busy) begin
      if (st_r.stag_cnt >= stag_gap(st_r.one[smc_pkg::STAG_HI -: 2])) begin // [RQ5]
        st_nxt.refresh = 1'b1;
        st_nxt.stag_cnt = 3'h0;
        st_nxt.bank = st_r.bank + 2'h1;
        st_nxt.ref_busy = st_r.bank != 2'h3;
      end else begin
        st_nxt.stag_cnt = st_r.stag_cnt + 3'h1;
      end
    end
    // Chip select, optionally one clock after the address.
    st_nxt.setup = 1'b0;
    st_nxt.cs = 1'b0;
    if (cmd_start) begin
      if (st_r.one[smc_pkg::SETUP_BIT]) begin // [RQ7]
        st_nxt.setup = 1'b1;
      end else begin
        st_nxt.cs = 1'b1;
      end
    end else if (st_r.setup) begin
      st_nxt.cs = 1'b1;
    end
    // Arbiter: display high first, then processor priority or round robin.
    st_nxt.gnt = smc_pkg::SMC_GNT_NONE;
    if (req_disp_hi) begin // [RQ10]
      st_nxt.gnt = smc_pkg::SMC_GNT_DISP;
    end else if (req_cpu && req_gfx && !st_r.one[smc_pkg::ARB_BIT]) begin // [RQ9]
      st_nxt.gnt = st_r.rr_last_cpu ? smc_pkg::SMC_GNT_GFX : smc_pkg::SMC_GNT_CPU;
    end else if (req_cpu) begin // [RQ9]
      st_nxt.gnt = smc_pkg::SMC_GNT_CPU;
    end else if (req_gfx) begin
      st_nxt.gnt = smc_pkg::SMC_GNT_GFX;
    end
    if (st_nxt.gnt == smc_pkg::SMC_GNT_CPU) begin
      st_nxt.rr_last_cpu = 1'b1;
    end else if (st_nxt.gnt == smc_pkg::SMC_GNT_GFX) begin
      st_nxt.rr_last_cpu = 1'b0;
    end
    // Read data; unmapped offsets read zero.
    case (reg_addr)
      smc_pkg::ADDR_CTRL_ONE: st_nxt.rdata = st_r.one;
      smc_pkg::ADDR_CTRL_TWO: st_nxt.rdata = st_r.two;
      default: st_nxt.rdata = '0;
    endcase
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.one <= smc_pkg::RST_CTRL_ONE;
      st_r.two <= smc_pkg::RST_CTRL_TWO;
      st_r.clk.ratio <= smc_pkg::RATIO_DEFAULT;
      st_r.gnt <= smc_pkg::SMC_GNT_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output decode of configuration fields.
  always_comb begin
    reg_rdata = st_r.rdata;
    grant = st_r.gnt;
    refresh_req = st_r.refresh;
    ref_bank = st_r.bank - 2'h1;
    mrs_cmd = st_r.mrs;
    mrs_latency = st_r.lat;
    cs_n = !st_r.cs;
    addr_valid = st_r.setup | st_r.cs; // [RQ7]
    clk_active = st_r.clk;
    clk_half_step = 4'(st_r.clk.ratio) + 4'h3; // [RQ1]
    access_block = !st_r.one[smc_pkg::WRAP_BIT]
      && access_addr[19:17] == 3'h5; // [RQ11]
    rise_delay = st_r.two[smc_pkg::RISE_HI -: 2]; // [RQ16]
    fall_delay = (st_r.clk.ratio == smc_pkg::RATIO_2P5 || st_r.clk.ratio == smc_pkg::RATIO_3P5)
      ? st_r.two[smc_pkg::FALL_HI -: 2] : 2'h0; // [RQ17]
    data_drv = st_r.one[smc_pkg::DATA_DRV_HI -: 3]; // [RQ14]
    addr_drv = st_r.one[smc_pkg::ADDR_DRV_HI -: 3]; // [RQ14]
    ctrl_drv = st_r.one[smc_pkg::CTRL_DRV_HI -: 3]; // [RQ14]
    clk_drv = (st_r.two[smc_pkg::CDRV_HI -: 3] == smc_pkg::DRV_TRI)
      ? smc_pkg::DRV_MAX : st_r.two[smc_pkg::CDRV_HI -: 3]; // [RQ15]
    fb_clk_en = !st_r.two[smc_pkg::FBMASK_BIT]; // [RQ18]
    mod_clk_en = ~st_r.two[smc_pkg::MODMASK_HI -: 4]; // [RQ19]
  end

  // Checks on the behaviour above.
  mrs_on_edge_a: assert property (@(posedge clock) disable iff (rst) // [RQ12]
    $rose(st_r.one[smc_pkg::MODE_BIT]) |=> mrs_cmd)
    else $error("mode command missed");
  ratio_hold_a: assert property (@(posedge clock) disable iff (rst) // [RQ2]
    !(st_r.one[smc_pkg::START_BIT] && !st_r.start_q) |=> $stable(clk_active))
    else $error("clock config changed without start edge");
  disp_first_a: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    req_disp_hi |=> grant == smc_pkg::SMC_GNT_DISP)
    else $error("display not granted first");
  cpu_prio_a: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (!req_disp_hi && req_cpu && st_r.one[smc_pkg::ARB_BIT]) |=> grant == smc_pkg::SMC_GNT_CPU)
    else $error("processor priority lost");
  setup_delay_a: assert property (@(posedge clock) disable iff (rst) // [RQ7]
    (cmd_start && st_r.one[smc_pkg::SETUP_BIT]) |=> cs_n ##1 !cs_n)
    else $error("setup clock missing");
  no_refresh_a: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    (st_r.one[smc_pkg::RINT_HI:smc_pkg::RINT_LO] == '0) |=> st_r.rcnt == '0)
    else $error("refresh counting while disabled");
  test_ref_a: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    ($rose(st_r.one[smc_pkg::TREF_BIT]) && !st_r.ref_busy) |=> st_r.ref_busy)
    else $error("test refresh ignored");
  clk_mask_a: assert property (@(posedge clock) disable iff (rst) // [RQ18]
    fb_clk_en != st_r.two[smc_pkg::FBMASK_BIT])
    else $error("feedback mask wrong");
  refresh_c: cover property (@(posedge clock) refresh_req);
  mrs_c: cover property (@(posedge clock) mrs_cmd);
  start_c: cover property (@(posedge clock) $changed(clk_active));
endmodule // smc_ctrl

// ---- test/smc_mem_model.sv ----
// Far-side memory model that counts the refresh and mode commands it receives.
module smc_mem_model (
  input wire logic clock, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic refresh_req, // Refresh pulse from the controller.
  input wire logic mrs_cmd, // Mode command pulse from the controller.
  output int ref_count, // Refresh pulses taken.
  output int mrs_count // Mode commands taken.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each one-cycle pulse is taken once, as a memory device would latch it.
  always @(posedge clock) begin
    if (rst) begin
      ref_count <= 0;
      mrs_count <= 0;
    end else begin
      ref_count <= ref_count + int'(refresh_req);
      mrs_count <= mrs_count + int'(mrs_cmd);
    end
  end
endmodule // smc_mem_model

// ---- test/sdram_ctrl_config_regs_test.sv ----
// Self-checking bench for the memory controller configuration block.
module sdram_ctrl_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic req_disp_hi = 1'b0;
  logic req_cpu = 1'b0;
  logic req_gfx = 1'b0;
  logic [19:0] access_addr = 20'h0_0000;
  logic cmd_start = 1'b0;
  logic [2:0] cas_lat = 3'h5;
  logic [31:0] reg_rdata, d, cur;
  smc_pkg::smc_gnt_e grant;
  smc_pkg::smc_clkcfg_s clk_active;
  logic access_block, cs_n, addr_valid, refresh_req, mrs_cmd, fb_clk_en;
  logic [1:0] ref_bank, rise_delay, fall_delay;
  logic [2:0] mrs_latency, data_drv, addr_drv, ctrl_drv, clk_drv, er, es;
  logic [3:0] clk_half_step, mod_clk_en;
  int ref_count, mrs_count, n, bad_count = 0, checks = 0;
  // Clock of 100 ns period.
  always #50 clock = ~clock;
  smc_ctrl smc_ctrl_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .req_disp_hi(req_disp_hi),
    .req_cpu(req_cpu), .req_gfx(req_gfx), .grant(grant), .access_addr(access_addr),
    .access_block(access_block), .cmd_start(cmd_start), .cs_n(cs_n), .addr_valid(addr_valid),
    .refresh_req(refresh_req), .ref_bank(ref_bank), .mrs_cmd(mrs_cmd),
    .cas_latency_setting(cas_lat), .mrs_latency(mrs_latency), .clk_active(clk_active),
    .clk_half_step(clk_half_step), .rise_delay(rise_delay), .fall_delay(fall_delay),
    .data_drv(data_drv), .addr_drv(addr_drv), .ctrl_drv(ctrl_drv), .clk_drv(clk_drv),
    .fb_clk_en(fb_clk_en), .mod_clk_en(mod_clk_en));
  smc_mem_model smc_mem_model_inst (.clock(clock), .rst(rst), .refresh_req(refresh_req),
    .mrs_cmd(mrs_cmd), .ref_count(ref_count), .mrs_count(mrs_count));
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register write: strobe stands for one edge.
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Register read: data is registered one cycle after the address.
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1 chk(reg_rdata, exp);
  endtask
  // Waits for the first bank pulse of a refresh burst; returns cycles waited.
  task automatic wait_ref(output int cyc);
    cyc = 0;
    do begin
      @(posedge clock);
      #1 cyc++;
    end while (!(refresh_req === 1'b1 && ref_bank === 2'h0) && cyc < 400);
    if (cyc >= 400) begin
      bad_count++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // Reset values, unmapped read, refresh off by default.
    rd(smc_pkg::ADDR_CTRL_ONE, smc_pkg::RST_CTRL_ONE);
    rd(smc_pkg::ADDR_CTRL_TWO, smc_pkg::RST_CTRL_TWO);
    rd(16'h8408, 32'h0000_0000);
    repeat (200) @(posedge clock);
    chk(32'(ref_count), 32'h0);
    $display("test reset done");
    // Every ratio code, reserved one included; ratio and shift wait for the start edge.
    er = smc_pkg::RATIO_DEFAULT;
    es = 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(smc_pkg::ADDR_CTRL_TWO, 32'h0000_c801 | (32'(c & 3) << 3));
      d = (smc_pkg::RST_CTRL_ONE & 32'hffe1_ffff) | (32'(c) << 18);
      wr(smc_pkg::ADDR_CTRL_ONE, d);
      repeat (3) @(posedge clock);
      #1 chk(32'(clk_active), {26'h0, er, es});
      wr(smc_pkg::ADDR_CTRL_ONE, d | 32'h0002_0000);
      if (c != 0) er = 3'(c);
      es = 3'(c & 3);
      repeat (3) @(posedge clock);
      #1 chk(32'(clk_active), {26'h0, er, es});
      chk(32'(clk_half_step), 32'(er) + 32'd3);
      chk(32'(fall_delay), (er == 3'h2 || er == 3'h4) ? 32'd3 : 32'd0);
    end
    $display("test clock ratio done");
    // Mode command after clear then set, carrying the latency setting.
    cur = d | 32'h0002_0000;
    wr(smc_pkg::ADDR_CTRL_ONE, cur | 32'h0000_0001);
    repeat (4) @(posedge clock);
    #1 chk(32'(mrs_count), 32'd1);
    chk(32'(mrs_latency), 32'h5);
    // Test refresh gives one burst of four bank pulses.
    wr(smc_pkg::ADDR_CTRL_ONE, cur | 32'h0000_0010);
    repeat (20) @(posedge clock);
    #1 chk(32'(ref_count), 32'd4);
    // Single bank setup: stagger zero gives four back-to-back bank pulses.
    wr(smc_pkg::ADDR_CTRL_ONE, cur & 32'hffff_ff3f);
    wr(smc_pkg::ADDR_CTRL_ONE, (cur & 32'hffff_ff3f) | 32'h0000_0010);
    repeat (20) @(posedge clock);
    #1 chk(32'(ref_count), 32'd8);
    $display("test mode and test refresh done");
    // Refresh interval of one and two units, then disabled again.
    for (int k = 1; k < 3; k++) begin
      wr(smc_pkg::ADDR_CTRL_ONE, cur | (32'(k) << 8));
      wait_ref(n);
      wait_ref(n);
      chk(32'(n), 32'(k * smc_pkg::REFRESH_UNIT));
    end
    wr(smc_pkg::ADDR_CTRL_ONE, cur);
    repeat (20) @(posedge clock);
    n = ref_count;
    repeat (300) @(posedge clock);
    chk(32'(ref_count), 32'(n));
    $display("test refresh interval done");
    // Legacy window blocked with wrap off, open with wrap on.
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(smc_pkg::ADDR_CTRL_ONE, cur | 32'h0000_0004);
      @(posedge clock);
      access_addr <= (i == 1) ? 20'hb_ffff : (i == 2) ? 20'h9_ffff
        : (i == 3) ? 20'hc_0000 : 20'ha_0000;
      @(posedge clock);
      #1 chk(32'(access_block), (i < 2) ? 32'd1 : 32'd0);
    end
    $display("test wrap done");
    // Display first always; processor first when the arbitration bit is set.
    wr(smc_pkg::ADDR_CTRL_ONE, (cur & 32'h007f_ffff) | 32'h1e80_0028);
    req_disp_hi <= 1'b1;
    req_cpu <= 1'b1;
    req_gfx <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(32'(grant), 32'(smc_pkg::SMC_GNT_DISP));
    @(posedge clock);
    req_disp_hi <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(32'(grant), 32'(smc_pkg::SMC_GNT_CPU));
    @(posedge clock);
    #1 chk(32'(grant), 32'(smc_pkg::SMC_GNT_CPU));
    chk({29'h0, data_drv}, 32'h0);
    chk({26'h0, addr_drv, ctrl_drv}, 32'h3d);
    // Extra address setup clock before select.
    @(posedge clock);
    cmd_start <= 1'b1;
    @(posedge clock);
    cmd_start <= 1'b0;
    #1 chk({30'h0, addr_valid, cs_n}, 32'h3);
    @(posedge clock);
    #1 chk(32'(cs_n), 32'h0);
    $display("test arbitration and setup done");
    // Clock drive zero reads as strongest; masks stop their outputs.
    wr(smc_pkg::ADDR_CTRL_TWO, 32'h0003_0680);
    repeat (2) @(posedge clock);
    #1 chk({25'h0, clk_drv, fb_clk_en, rise_delay, 1'b0}, 32'h76);
    chk(32'(mod_clk_en), 32'h5);
    $display("test clock outputs done");
    give_verdict();
  end
endmodule // sdram_ctrl_config_regs_test
